// ===== adcc_core.v
/*
 * adcc_core.v: digital control and output port of a pipelined 14-bit
 * sampling converter: reset, self-trim, power-down, 13-cycle pipeline,
 * saturation, two's complement output, read-enabled drivers.
 * assumes: the host drives the control pins from outside this clock
 * domain, so each passes a two-stage synchroniser; the analog front end
 * supplies one raw signed sample and two range flags per clock.
 */
// Overview of operation
// - calibration lasts 272,800 clock cycles
// - output meaningless during reset/trim plus 13
// - drivers active while read enable low
// - low power while power_down_n low, wake after
// - pipeline lost in power-down; reset, recalibrate
// - conversion-valid low whenever data valid and read enable low
// - fourteen data bits plus valid indicator
// - samples encoded in two's complement
// - sign bit low when positive exceeds negative
// - zero differential gives all-zero code
// - one word per cycle, 13 cycles latency; the code adds fifo and output flops, 16 cycles from sampleIn to dataOut
// - out-of-range inputs saturate to full-scale codes
`timescale 1ns/100ps
`include "adcc_map.vh"

module adcc_core (
    input  wire                     ref_clk,
    input  wire                     arst_n,
    input  wire                     resetReq,
    input  wire                     trimReq,
    input  wire                     readEnable_n,
    input  wire                     power_down_n,
    input  wire [`ADCC_DATA_W-1:0]  sampleIn,
    input  wire                     overRange,
    input  wire                     underRange,
    output reg  [`ADCC_DATA_W-1:0]  dataOut,
    output reg  [`ADCC_DATA_W-1:0]  dataOutEn,
    output reg                      convValid_n,
    output reg                      lowPower,
    output reg                      calBusy,
    output reg                      fifoOverflow
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    reg [3:0] syncA_reg;
    reg [3:0] syncB_reg;
    wire      rstS  = syncB_reg[0];
    wire      trimS = syncB_reg[1];
    wire      rdnS  = syncB_reg[2];
    wire      pdnS  = syncB_reg[3];

    // two flops per pin; only syncB reads syncA; reset to idle levels so no false sleep
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_reg <= `ADCC_SYNC_IDLE;
            syncB_reg <= `ADCC_SYNC_IDLE;
        end else begin
            syncA_reg <= {power_down_n, readEnable_n, trimReq, resetReq};
            syncB_reg <= syncA_reg;
        end
    end

    // ---------------------------------------------------------------
    // mode state machine
    // ---------------------------------------------------------------
    reg [2:0]              state_reg;
    reg [2:0]              state_next;
    reg [`ADCC_CNT_W-1:0]  count_reg;
    reg [`ADCC_CNT_W-1:0]  count_next;
    reg                    trimPrev_reg;
    wire                   trimRise = trimS && !trimPrev_reg;

    // sequencing of reset, trim, settling and sleep
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            `ADCC_ST_RUN: begin
                if (!pdnS)
                    state_next = `ADCC_ST_SLEEP;
                else if (rstS)
                    state_next = `ADCC_ST_RESET;
                else if (trimRise) begin
                    state_next = `ADCC_ST_CAL;
                    count_next = `ADCC_CAL_CYCLES;
                end
            end
            `ADCC_ST_RESET: begin
                if (!pdnS)
                    state_next = `ADCC_ST_SLEEP;
                else if (!rstS) begin
                    state_next = `ADCC_ST_SETTLE;
                    count_next = {{(`ADCC_CNT_W-5){1'b0}}, `ADCC_LATENCY};
                end
            end
            `ADCC_ST_CAL: begin
                if (!pdnS)
                    state_next = `ADCC_ST_SLEEP;
                else if (rstS)
                    state_next = `ADCC_ST_RESET;
                else if (count_reg != {`ADCC_CNT_W{1'b0}})
                    count_next = count_reg - 1'b1;
                else if (!trimS) begin
                    state_next = `ADCC_ST_SETTLE;
                    count_next = {{(`ADCC_CNT_W-5){1'b0}}, `ADCC_LATENCY};
                end
            end
            `ADCC_ST_SETTLE: begin
                if (!pdnS)
                    state_next = `ADCC_ST_SLEEP;
                else if (rstS)
                    state_next = `ADCC_ST_RESET;
                else if (trimRise) begin
                    state_next = `ADCC_ST_CAL;
                    count_next = `ADCC_CAL_CYCLES;
                end else if (count_reg != {`ADCC_CNT_W{1'b0}})
                    count_next = count_reg - 1'b1;
                else
                    state_next = `ADCC_ST_RUN;
            end
            `ADCC_ST_SLEEP: begin
                if (pdnS) begin
                    state_next = `ADCC_ST_WAKE;
                    count_next = `ADCC_WAKE_CYCLES;
                end
            end
            `ADCC_ST_WAKE: begin
                if (!pdnS)
                    state_next = `ADCC_ST_SLEEP;
                else if (rstS)
                    state_next = `ADCC_ST_RESET;
                else if (count_reg != {`ADCC_CNT_W{1'b0}})
                    count_next = count_reg - 1'b1;
                else begin
                    state_next = `ADCC_ST_SETTLE;
                    count_next = {{(`ADCC_CNT_W-5){1'b0}}, `ADCC_LATENCY};
                end
            end
            default: begin
                state_next = `ADCC_ST_RESET;
            end
        endcase
    end

    // state registers
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= `ADCC_ST_RESET;
            count_reg    <= {`ADCC_CNT_W{1'b0}};
            trimPrev_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            trimPrev_reg <= trimS;
        end
    end

    // ---------------------------------------------------------------
    // conversion pipeline
    // ---------------------------------------------------------------
    wire                    running = (state_reg == `ADCC_ST_RUN);
    wire                    asleep  = (state_reg == `ADCC_ST_SLEEP);
    reg  [`ADCC_DATA_W-1:0] clipped;

    // saturate out-of-range samples; sign/zero kept as two's complement
    always @* begin
        if (underRange)
            clipped = `ADCC_CODE_MAXNEG;
        else if (overRange)
            clipped = `ADCC_CODE_MAXPOS;
        else
            clipped = sampleIn;
    end

    reg [`ADCC_DATA_W-1:0] pipeData [0:12];
    reg [12:0]             pipeValid_reg;
    integer                i;

    // thirteen stages, one word per clock; cleared while asleep
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 13; i = i + 1)
                pipeData[i] <= `ADCC_CODE_ZERO;
            pipeValid_reg <= 13'h0000;
        end else begin
            pipeData[0] <= asleep ? `ADCC_CODE_ZERO : clipped;
            for (i = 1; i < 13; i = i + 1)
                pipeData[i] <= asleep ? `ADCC_CODE_ZERO : pipeData[i-1];
            pipeValid_reg <= {pipeValid_reg[11:0], running};
            if (!running)
                pipeValid_reg <= 13'h0000;
        end
    end

    // ---------------------------------------------------------------
    // output fifo and port
    // ---------------------------------------------------------------
    wire                    fifoInReady;
    wire [`ADCC_DATA_W-1:0] fifoData;
    wire                    fifoValid;
    wire                    pushWord = pipeValid_reg[12];

    adcc_fifo #(
        .WIDTH (`ADCC_DATA_W),
        .DEPTH (`ADCC_FIFO_DEPTH),
        .AW    (`ADCC_FIFO_AW)
    ) uFifo (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .flush    (!running),
        .inData   (pipeData[12]),
        .inValid  (pushWord),
        .inReady  (fifoInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (!rdnS)
    );

    // drive pins from flops; valid strobe only while data is good
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataOut      <= `ADCC_CODE_ZERO;
            dataOutEn    <= 14'h0000;
            convValid_n  <= 1'b1;
            lowPower     <= 1'b0;
            calBusy      <= 1'b0;
            fifoOverflow <= 1'b0;
        end else begin
            dataOut      <= fifoData;
            dataOutEn    <= {`ADCC_DATA_W{!rdnS}};
            convValid_n  <= !(fifoValid && !rdnS && running);
            lowPower     <= asleep;
            calBusy      <= (state_reg == `ADCC_ST_CAL);
            if (!running)
                fifoOverflow <= 1'b0;
            else if (pushWord && !fifoInReady)
                fifoOverflow <= 1'b1;
        end
    end
endmodule // adcc_core

// ===== adcc_map.vh
/*
 * adcc_map.vh: constants for the converter control and output port.
 * assumes: included by the design files of this block, by bare name.
 */
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// ---------------------------------------------------------------
// widths and codes
// ---------------------------------------------------------------
`define ADCC_DATA_W      14
`define ADCC_CODE_MAXPOS 14'h1fff
`define ADCC_CODE_MAXNEG 14'h2000
`define ADCC_CODE_ZERO   14'h0000

// ---------------------------------------------------------------
// timing, in sample-clock cycles
// ---------------------------------------------------------------
`define ADCC_LATENCY     5'h0d
`define ADCC_CAL_CYCLES  19'h429a0
`define ADCC_CNT_W       19
`define ADCC_WAKE_CYCLES 19'h00010
`define ADCC_SYNC_IDLE   4'hc       // idle pin levels: power_down_n and read enable high

// ---------------------------------------------------------------
// fifo and states
// ---------------------------------------------------------------
`define ADCC_FIFO_DEPTH  16
`define ADCC_FIFO_AW     4
`define ADCC_ST_RUN      3'h0
`define ADCC_ST_RESET    3'h1
`define ADCC_ST_CAL      3'h2
`define ADCC_ST_SETTLE   3'h3
`define ADCC_ST_SLEEP    3'h4
`define ADCC_ST_WAKE     3'h5

`endif

// ===== adcc_fifo.v
/*
 * adcc_fifo.v: synchronous fifo with valid/ready on both sides.
 * assumes: one clock, asynchronous active-low reset, flush from owner.
 */
`timescale 1ns/100ps

module adcc_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             arst_n,
    input  wire             flush,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output reg  [WIDTH-1:0] outData,
    output reg              outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_reg;
    reg [AW:0]      rdPtr_reg;
    wire            emptyMem = (wrPtr_reg == rdPtr_reg);
    wire            fullMem  = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                               (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    wire            pop      = !emptyMem && (!outValid || outReady);
    wire            push     = inValid && !fullMem;

    assign inReady = !fullMem;

    // ---------------------------------------------------------------
    // storage and pointers; output word held in a register
    // ---------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (push)
            mem[wrPtr_reg[AW-1:0]] <= inData;
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
            outData   <= {WIDTH{1'b0}};
            outValid  <= 1'b0;
        end else if (flush) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
            outValid  <= 1'b0;
        end else begin
            if (push)
                wrPtr_reg <= wrPtr_reg + 1'b1;
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
                outData   <= mem[rdPtr_reg[AW-1:0]];
                outValid  <= 1'b1;
            end else if (outReady) begin
                outValid  <= 1'b0;
            end
        end
    end
endmodule // adcc_fifo

// ===== adcc_checker.sv
/* adcc_checker.sv: concurrent checks on the pins of the converter port.
   assumes: bound to adcc_core, one clock, arst_n asynchronous active low. */
`timescale 1ns/100ps

module adcc_checker (
    input logic        ref_clk,
    input logic        arst_n,
    input logic        resetReq,
    input logic        trimReq,
    input logic        readEnable_n,
    input logic        power_down_n,
    input logic [13:0] dataOutEn,
    input logic        convValid_n,
    input logic        lowPower,
    input logic        calBusy
);
    // ------------------------------------------------------------
    // pin relations
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_drivers_off: assert property (readEnable_n[*5] |-> dataOutEn == 14'h0000)
        else $error("drivers on while read enable high");
    a_drivers_on: assert property ((!readEnable_n)[*5] |-> dataOutEn == 14'h3fff)
        else $error("drivers off while read enable low");
    a_reset_hides_valid: assert property ($fell(resetReq) |-> ##1 convValid_n[*8] ##1 convValid_n[*5])
        else $error("valid strobe within settle after reset");
    a_cal_hides_valid: assert property (calBusy |-> convValid_n)
        else $error("valid strobe during calibration");
    a_sleep_hides_valid: assert property (lowPower |-> convValid_n)
        else $error("valid strobe while asleep");
    a_sleep_entry: assert property ((!power_down_n)[*5] |-> lowPower)
        else $error("no low power state while power down held");
    a_wake_bound: assert property ($rose(power_down_n) |-> ##[1:30] !lowPower)
        else $error("no wake after power down released");
    a_trim_starts: assert property (trimReq[*3] |-> ##[0:3] calBusy)
        else $error("trim request did not start calibration");
    a_cal_runs_on: assert property ($rose(calBusy) |-> calBusy[*8])
        else $error("calibration ended early");
endmodule // adcc_checker

bind adcc_core adcc_checker chk (.ref_clk(ref_clk), .arst_n(arst_n), .resetReq(resetReq), .trimReq(trimReq),
    .readEnable_n(readEnable_n), .power_down_n(power_down_n), .dataOutEn(dataOutEn),
    .convValid_n(convValid_n), .lowPower(lowPower), .calBusy(calBusy));

// ===== adcc_host_model.sv
/* adcc_host_model.sv: host side that captures converter words.
   assumes: one clock; a released data line shows the inverse of its last level. */
`timescale 1ns/100ps

module adcc_host_model (
    input  logic        ref_clk,
    input  logic [13:0] dataOut,
    input  logic [13:0] dataOutEn,
    input  logic        convValid_n,
    output logic [13:0] capWord,
    output logic        capStrobe
);
    logic [13:0] lineLevel;
    logic [13:0] lastLevel = 14'h0000;

    // undriven lines flip, so a missing driver never looks like data
    assign lineLevel = (dataOut & dataOutEn) | (~lastLevel & ~dataOutEn);

    // latch the lines on every rising edge; capStrobe records whether the valid strobe was low
    always @(posedge ref_clk) begin
        lastLevel <= lineLevel;
        capWord   <= lineLevel;
        capStrobe <= !convValid_n;
    end
endmodule // adcc_host_model

// ===== adc_control_and_output_port_bench.sv
/* adc_control_and_output_port_bench.sv: self-checking bench for adcc_core.
   assumes: core, fifo, host model and checker compiled before this file. */
`timescale 1ns/100ps
`include "adcc_map.vh"
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin failCount++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module adc_control_and_output_port_bench;
    logic        ref_clk, arst_n, resetReq, trimReq, readEnable_n, power_down_n, overRange, underRange;
    logic [13:0] sampleIn, dataOut, dataOutEn, capWord;
    logic        convValid_n, lowPower, calBusy, fifoOverflow, capStrobe;
    logic [13:0] capQ[$];
    logic [13:0] vecIn[8], vecExp[8];
    logic        vecOver[8], vecUnder[8];
    int          failCount = 0, totalChecks = 0, cycles = 0;

    adcc_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .resetReq(resetReq), .trimReq(trimReq),
        .readEnable_n(readEnable_n), .power_down_n(power_down_n), .sampleIn(sampleIn),
        .overRange(overRange), .underRange(underRange), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .convValid_n(convValid_n), .lowPower(lowPower), .calBusy(calBusy), .fifoOverflow(fifoOverflow));
    adcc_host_model host (.ref_clk(ref_clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .convValid_n(convValid_n), .capWord(capWord), .capStrobe(capStrobe));

    // ------------------------------------------------------------
    // clock, capture queue, hang limit
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // collect host captures and cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (capStrobe === 1'b1) capQ.push_back(capWord);
        if (cycles == 3000) begin
            failCount++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic pulse(ref logic sig, input int n);
        sig = 1'b1;
        tick(n);
        sig = 1'b0;
        tick(1);
    endtask

    // feed the code table one sample a cycle, then find it in the capture stream
    task automatic run_burst(input string nm);
        int k;
        k = -1;
        capQ.delete();
        for (int i = 0; i < 8; i++) begin
            sampleIn = vecIn[i];
            overRange = vecOver[i];
            underRange = vecUnder[i];
            tick(1);
        end
        sampleIn = 14'h0aaa;
        overRange = 1'b0;
        underRange = 1'b0;
        tick(60);
        for (int i = 0; i < capQ.size(); i++) if (k < 0 && capQ[i] === vecExp[0]) k = i;
        for (int i = 0; i < 8; i++) `CHK(nm, vecExp[i], (k >= 0 && k + i < capQ.size()) ? capQ[k + i] : 14'hxxxx)
        $display("test %s done", nm);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        resetReq = 1'b0;
        trimReq = 1'b0;
        readEnable_n = 1'b1;
        power_down_n = 1'b1;
        sampleIn = 14'h0aaa;
        overRange = 1'b0;
        underRange = 1'b0;
        vecIn = '{14'h0000, 14'h1234, 14'h3abc, 14'h0001, 14'h2222, 14'h0333, 14'h1fff, 14'h2000};
        vecOver = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        vecUnder = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        vecExp = '{`ADCC_CODE_ZERO, 14'h1234, 14'h3abc, `ADCC_CODE_MAXPOS, `ADCC_CODE_MAXNEG,
                   `ADCC_CODE_MAXNEG, 14'h1fff, 14'h2000};
        tick(8);
        arst_n = 1'b1;
        pulse(resetReq, 4);
        readEnable_n = 1'b0;
        tick(30);
        `CHK("drivers on", 14'h3fff, dataOutEn)
        run_burst("codes");
        readEnable_n = 1'b1;
        tick(40);
        `CHK("drivers off", 14'h0000, dataOutEn)
        `CHK("overflow", 1'b1, fifoOverflow)
        `CHK("valid stalled", 1'b1, convValid_n)
        readEnable_n = 1'b0;
        tick(4);
        run_burst("after stall");
        power_down_n = 1'b0;
        tick(10);
        `CHK("sleeping", 1'b1, lowPower)
        power_down_n = 1'b1;
        tick(30);
        `CHK("awake", 1'b0, lowPower)
        $display("test sleep done");
        pulse(resetReq, 4);
        pulse(trimReq, 4);
        tick(10);
        `CHK("cal busy", 1'b1, calBusy)
        `CHK("valid in cal", 1'b1, convValid_n)
        pulse(resetReq, 4);
        tick(30);
        `CHK("cal aborted", 1'b0, calBusy)
        $display("test calibration done");
        run_burst("after cal");
        tally_and_finish();
    end
endmodule // adc_control_and_output_port_bench
